// ---- inc/sstm_defines.svh ----
// Constants for the serial SPI trigger matcher: widths, limits, reset values
`ifndef SSTM_DEFINES_SVH
`define SSTM_DEFINES_SVH
`define SSTM_NUM_ANA       4
`define SSTM_NUM_DIG       16
`define SSTM_CODE_W        8
`define SSTM_SRC_W         5
`define SSTM_SRC_LAST      5'h13
`define SSTM_THR_W         8
`define SSTM_PAT_MAX       96
`define SSTM_LEN_W         7
`define SSTM_LEN_MIN       7'h04
`define SSTM_LEN_MAX       7'h60
`define SSTM_TMO_NS_W      23
`define SSTM_TMO_CYC_W     19
`define SSTM_CLK_PERIOD_NS 10
`define SSTM_TMO_MIN_NS    100
`define SSTM_TMO_MAX_NS    5000000
`define SSTM_RST_SRC       5'h00
`define SSTM_RST_THR       8'h80
`define SSTM_RST_LEN       7'h08
`define SSTM_RST_TMO_NS    23'h0007D0
`endif

// ---- inc/sstm_pkg.sv ----
// Types shared by the serial SPI trigger matcher
package sstm_pkg;
    typedef enum logic [1:0] {SSTM_FRM_CS, SSTM_FRM_NCS, SSTM_FRM_TMO} sstm_frame_t;
    typedef enum logic {SSTM_LINE_MOSI, SSTM_LINE_MISO} sstm_line_t;
    typedef enum logic {SSTM_ORDER_MSB, SSTM_ORDER_LSB} sstm_order_t;
    typedef enum logic {SSTM_EDGE_RISE, SSTM_EDGE_FALL} sstm_edge_t;
    typedef enum logic [1:0] {SSTM_ST_IDLE, SSTM_ST_COLLECT, SSTM_ST_DONE} sstm_state_t;
endpackage

// ---- core/sstm_sync.sv ----
// Two-flop synchroniser bank for the digital probe lines
`timescale 1ns/1ps
module sstm_sync #(
    parameter int W = 16
) (
    input  wire logic         mclk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // First stage feeds only the second stage
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule

// ---- core/sstm_trigger.sv ----
// Serial SPI pattern trigger: source slicing, framing, sampling and matching
// Functional notes
// - Slave-out source from any channel, readable back
// - Analog sources sliced against their own threshold
// - Framing by select, inverted select, or timeout
// - True-sense select taken from selectable channel
// - Inverted select has its own source setting
// - Pattern compared against one chosen data line
// - Each pattern bit is zero, one or don't-care
// - Pattern length four to ninety-six bits
// - Selectable MSB-first or LSB-first bit alignment
// - Settings read back; pattern is write-only
// - Data sampled on selected serial clock edge
// - Clock idle beyond timeout ends the transfer
`timescale 1ns/1ps
`include "sstm_defines.svh"
module sstm_trigger
    import sstm_pkg::*;
(
    input  wire logic                       mclk_i,
    input  wire logic                       nrst_i,
    input  wire logic [31:0]                ana_codes_i,
    input  wire logic [15:0]                dig_lines_i,
    input  wire logic                       cfg_wr_i,
    input  wire logic [`SSTM_SRC_W-1:0]     serial_clock_source_select_i,
    input  wire logic [`SSTM_THR_W-1:0]     serial_clock_threshold_i,
    input  wire logic [`SSTM_SRC_W-1:0]     master_out_source_select_i,
    input  wire logic [`SSTM_THR_W-1:0]     master_out_threshold_i,
    input  wire logic [`SSTM_SRC_W-1:0]     slave_out_source_select_i,
    input  wire logic [`SSTM_THR_W-1:0]     slave_out_threshold_i,
    input  wire logic [`SSTM_SRC_W-1:0]     select_line_source_i,
    input  wire logic [`SSTM_THR_W-1:0]     select_line_threshold_i,
    input  wire logic [`SSTM_SRC_W-1:0]     inverted_select_line_source_i,
    input  wire logic [`SSTM_THR_W-1:0]     inverted_select_line_threshold_i,
    input  wire sstm_frame_t                framing_type_select_i,
    input  wire sstm_line_t                 watched_data_line_i,
    input  wire logic [`SSTM_LEN_W-1:0]     pattern_length_i,
    input  wire sstm_order_t                bit_order_select_i,
    input  wire sstm_edge_t                 sample_edge_select_i,
    input  wire logic [`SSTM_TMO_NS_W-1:0]  clock_idle_timeout_i,
    input  wire logic [`SSTM_PAT_MAX-1:0]   bit_pattern_i,
    input  wire logic [`SSTM_PAT_MAX-1:0]   bit_pattern_care_i,
    output logic [`SSTM_SRC_W-1:0]          serial_clock_source_select_o,
    output logic [`SSTM_THR_W-1:0]          serial_clock_threshold_o,
    output logic [`SSTM_SRC_W-1:0]          master_out_source_select_o,
    output logic [`SSTM_THR_W-1:0]          master_out_threshold_o,
    output logic [`SSTM_SRC_W-1:0]          slave_out_source_select_o,
    output logic [`SSTM_THR_W-1:0]          slave_out_threshold_o,
    output logic [`SSTM_SRC_W-1:0]          select_line_source_o,
    output logic [`SSTM_THR_W-1:0]          select_line_threshold_o,
    output logic [`SSTM_SRC_W-1:0]          inverted_select_line_source_o,
    output logic [`SSTM_THR_W-1:0]          inverted_select_line_threshold_o,
    output sstm_frame_t                     framing_type_select_o,
    output sstm_line_t                      watched_data_line_o,
    output logic [`SSTM_LEN_W-1:0]          pattern_length_o,
    output sstm_order_t                     bit_order_select_o,
    output sstm_edge_t                      sample_edge_select_o,
    output logic [`SSTM_TMO_NS_W-1:0]       clock_idle_timeout_o,
    output logic                            trigger_o,
    output logic                            frame_active_o,
    output logic [`SSTM_LEN_W-1:0]          bit_count_o
);
    localparam int I_CLK = 0;
    localparam int I_MOSI = 1;
    localparam int I_MISO = 2;
    localparam int I_CS = 3;
    localparam int I_NCS = 4;

    // Level of a source: analog code sliced by threshold, or a synced digital line
    function automatic logic slice(input logic [`SSTM_SRC_W-1:0] sel,
                                   input logic [`SSTM_THR_W-1:0] thr,
                                   input logic [31:0] ana, input logic [15:0] dig);
        logic [`SSTM_SRC_W-1:0] di;
        begin
            di = sel - 5'h04;
            if (sel < 5'h04) slice = (ana[sel[1:0]*`SSTM_CODE_W +: `SSTM_CODE_W] >= thr);
            else if (sel <= `SSTM_SRC_LAST) slice = dig[di[3:0]];
            else slice = 1'b0;
        end
    endfunction

    // Source codes above the last digital line are refused on write
    function automatic logic [`SSTM_SRC_W-1:0] pick_src(input logic [`SSTM_SRC_W-1:0] nw,
                                                         input logic [`SSTM_SRC_W-1:0] od);
        pick_src = (nw <= `SSTM_SRC_LAST) ? nw : od;
    endfunction

    // Idle time to cycles, rounded up since it is a least time
    function automatic logic [`SSTM_TMO_CYC_W-1:0] ns_to_cyc(input logic [`SSTM_TMO_NS_W-1:0] ns);
        logic [`SSTM_TMO_NS_W-1:0] c;
        begin
            c = ns;
            if (ns < `SSTM_TMO_NS_W'(`SSTM_TMO_MIN_NS)) c = `SSTM_TMO_NS_W'(`SSTM_TMO_MIN_NS);
            if (ns > `SSTM_TMO_NS_W'(`SSTM_TMO_MAX_NS)) c = `SSTM_TMO_NS_W'(`SSTM_TMO_MAX_NS);
            ns_to_cyc = `SSTM_TMO_CYC_W'((c + `SSTM_TMO_NS_W'(`SSTM_CLK_PERIOD_NS - 1))
                                         / `SSTM_TMO_NS_W'(`SSTM_CLK_PERIOD_NS));
        end
    endfunction

    logic [15:0]                  dig_s;
    logic [`SSTM_SRC_W-1:0]       src_sel_r [5];
    logic [`SSTM_THR_W-1:0]       src_thr_r [5];
    sstm_frame_t                  frm_r;
    sstm_line_t                   line_r;
    sstm_order_t                  order_r;
    sstm_edge_t                   edge_r;
    logic [`SSTM_LEN_W-1:0]       len_r;
    logic [`SSTM_TMO_NS_W-1:0]    tmo_ns_r;
    logic [`SSTM_TMO_CYC_W-1:0]   tmo_cyc_r;
    logic [`SSTM_PAT_MAX-1:0]     pat_r;
    logic [`SSTM_PAT_MAX-1:0]     care_r;
    logic [4:0]                   lvl_r;
    logic                         clk_prev_r;
    logic [`SSTM_TMO_CYC_W-1:0]   idle_cnt_r;
    logic                         tmo_act_r;
    logic                         frame_r;
    sstm_state_t                  st_r;
    logic [`SSTM_LEN_W-1:0]       cnt_r;
    logic [`SSTM_PAT_MAX-1:0]     cap_r;
    logic                         trig_r;
    logic                         clk_edge;
    logic                         samp;
    logic                         frame_now;
    logic                         start;
    logic                         data_bit;
    logic [`SSTM_LEN_W-1:0]       cnt_eff;
    logic [`SSTM_LEN_W-1:0]       pos;
    logic [`SSTM_PAT_MAX-1:0]     cap_nxt;
    logic [`SSTM_PAT_MAX-1:0]     len_mask;
    logic                         last_bit;
    logic                         hit;

    sstm_sync #(.W(`SSTM_NUM_DIG)) u_sync (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .async_i (dig_lines_i),
        .sync_o  (dig_s)
    );

    // Settings latched as one set so a half-written setup never reaches the matcher
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 5; i++) begin
                src_sel_r[i] <= `SSTM_RST_SRC;
                src_thr_r[i] <= `SSTM_RST_THR;
            end
            frm_r     <= SSTM_FRM_CS;
            line_r    <= SSTM_LINE_MOSI;
            order_r   <= SSTM_ORDER_MSB;
            edge_r    <= SSTM_EDGE_RISE;
            len_r     <= `SSTM_RST_LEN;
            tmo_ns_r  <= `SSTM_RST_TMO_NS;
            tmo_cyc_r <= ns_to_cyc(`SSTM_RST_TMO_NS);
            pat_r     <= '0;
            care_r    <= '0;
        end else if (cfg_wr_i) begin
            src_sel_r[I_CLK]  <= pick_src(serial_clock_source_select_i, src_sel_r[I_CLK]);
            src_sel_r[I_MOSI] <= pick_src(master_out_source_select_i, src_sel_r[I_MOSI]);
            src_sel_r[I_MISO] <= pick_src(slave_out_source_select_i, src_sel_r[I_MISO]);
            src_sel_r[I_CS]   <= pick_src(select_line_source_i, src_sel_r[I_CS]);
            src_sel_r[I_NCS]  <= pick_src(inverted_select_line_source_i, src_sel_r[I_NCS]);
            src_thr_r[I_CLK]  <= serial_clock_threshold_i;
            src_thr_r[I_MOSI] <= master_out_threshold_i;
            src_thr_r[I_MISO] <= slave_out_threshold_i;
            src_thr_r[I_CS]   <= select_line_threshold_i;
            src_thr_r[I_NCS]  <= inverted_select_line_threshold_i;
            if (framing_type_select_i != 2'h3) frm_r <= framing_type_select_i;
            line_r    <= watched_data_line_i;
            order_r   <= bit_order_select_i;
            edge_r    <= sample_edge_select_i;
            // Out-of-range lengths are clamped rather than refused
            len_r     <= (pattern_length_i < `SSTM_LEN_MIN) ? `SSTM_LEN_MIN :
                         (pattern_length_i > `SSTM_LEN_MAX) ? `SSTM_LEN_MAX :
                         pattern_length_i;
            tmo_ns_r  <= clock_idle_timeout_i;
            tmo_cyc_r <= ns_to_cyc(clock_idle_timeout_i);
            pat_r     <= bit_pattern_i;
            care_r    <= bit_pattern_care_i;
        end
    end

    // Readback of every setting except the pattern
    assign serial_clock_source_select_o     = src_sel_r[I_CLK];
    assign serial_clock_threshold_o         = src_thr_r[I_CLK];
    assign master_out_source_select_o       = src_sel_r[I_MOSI];
    assign master_out_threshold_o           = src_thr_r[I_MOSI];
    assign slave_out_source_select_o        = src_sel_r[I_MISO];
    assign slave_out_threshold_o            = src_thr_r[I_MISO];
    assign select_line_source_o             = src_sel_r[I_CS];
    assign select_line_threshold_o          = src_thr_r[I_CS];
    assign inverted_select_line_source_o    = src_sel_r[I_NCS];
    assign inverted_select_line_threshold_o = src_thr_r[I_NCS];
    assign framing_type_select_o            = frm_r;
    assign watched_data_line_o              = line_r;
    assign pattern_length_o                 = len_r;
    assign bit_order_select_o               = order_r;
    assign sample_edge_select_o             = edge_r;
    assign clock_idle_timeout_o             = tmo_ns_r;

    // Slice all five sources; clock and data share one register stage so they stay aligned
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lvl_r      <= '0;
            clk_prev_r <= 1'b0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                lvl_r[i] <= slice(src_sel_r[i], src_thr_r[i], ana_codes_i, dig_s);
            end
            clk_prev_r <= lvl_r[I_CLK];
        end
    end

    // Edge detection, framing and bit placement
    always_comb begin
        clk_edge = lvl_r[I_CLK] ^ clk_prev_r;
        samp = (edge_r == SSTM_EDGE_RISE) ? (lvl_r[I_CLK] & ~clk_prev_r)
                                          : (~lvl_r[I_CLK] & clk_prev_r);
        case (frm_r)
            SSTM_FRM_CS:  frame_now = lvl_r[I_CS];
            SSTM_FRM_NCS: frame_now = ~lvl_r[I_NCS];
            SSTM_FRM_TMO: frame_now = tmo_act_r | clk_edge;
            default:      frame_now = 1'b0;
        endcase
        start    = frame_now & ~frame_r;
        data_bit = (line_r == SSTM_LINE_MISO) ? lvl_r[I_MISO] : lvl_r[I_MOSI];
        cnt_eff  = start ? '0 : cnt_r;
        pos      = (order_r == SSTM_ORDER_MSB) ? (len_r - 7'h01 - cnt_eff) : cnt_eff;
        cap_nxt  = cap_r;
        cap_nxt[pos] = data_bit;
        len_mask = ~(~{`SSTM_PAT_MAX{1'b0}} << len_r);
        last_bit = (cnt_eff == len_r - 7'h01);
        hit = frame_now & samp & (start || st_r == SSTM_ST_COLLECT) & last_bit
              & (((cap_nxt ^ pat_r) & care_r & len_mask) == '0);
    end

    // Idle timer; any clock transition restarts it
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idle_cnt_r <= '0;
            tmo_act_r  <= 1'b0;
        end else if (clk_edge) begin
            idle_cnt_r <= '0;
            tmo_act_r  <= 1'b1;
        end else if (idle_cnt_r >= tmo_cyc_r) begin
            tmo_act_r  <= 1'b0;
        end else begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
        end
    end

    // Collection state: partial bits drop when the frame closes
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r    <= SSTM_ST_IDLE;
            cnt_r   <= '0;
            cap_r   <= '0;
            frame_r <= 1'b0;
            trig_r  <= 1'b0;
        end else begin
            frame_r <= frame_now;
            trig_r  <= hit;
            if (!frame_now) begin
                st_r  <= SSTM_ST_IDLE;
                cnt_r <= '0;
            end else begin
                case (st_r)
                    SSTM_ST_IDLE, SSTM_ST_COLLECT: begin
                        if (start || st_r == SSTM_ST_COLLECT) begin
                            st_r <= SSTM_ST_COLLECT;
                            if (samp) begin
                                cap_r <= cap_nxt;
                                cnt_r <= cnt_eff + 7'h01;
                                if (last_bit) st_r <= SSTM_ST_DONE;
                            end else begin
                                cnt_r <= cnt_eff;
                            end
                        end
                    end
                    SSTM_ST_DONE: st_r <= SSTM_ST_DONE; // One trigger per frame
                    default: st_r <= SSTM_ST_IDLE;
                endcase
            end
        end
    end

    assign trigger_o      = trig_r;
    assign frame_active_o = frame_r;
    assign bit_count_o    = cnt_r;

    // Checks on the matcher
    property p_trig_cause;
        @(posedge mclk_i) disable iff (!nrst_i) trigger_o |-> $past(hit) && st_r == SSTM_ST_DONE;
    endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("trigger without match");

    property p_one_trig;
        @(posedge mclk_i) disable iff (!nrst_i) trigger_o |=> !trigger_o [*2];
    endproperty
    a_one_trig: assert property (p_one_trig) else $error("trigger repeated");

    property p_idle_clear;
        @(posedge mclk_i) disable iff (!nrst_i) !frame_active_o |-> bit_count_o == 7'h00;
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("bits kept outside frame");

    sequence s_ncs_steady;
        frm_r == SSTM_FRM_NCS ##1 frm_r == SSTM_FRM_NCS;
    endsequence
    property p_ncs_frame;
        @(posedge mclk_i) disable iff (!nrst_i)
            s_ncs_steady |-> frame_active_o == !$past(lvl_r[I_NCS]);
    endproperty
    a_ncs_frame: assert property (p_ncs_frame) else $error("inverted select framing");

    property p_cs_frame;
        @(posedge mclk_i) disable iff (!nrst_i)
            frm_r == SSTM_FRM_CS ##1 frm_r == SSTM_FRM_CS |-> frame_active_o == $past(lvl_r[I_CS]);
    endproperty
    a_cs_frame: assert property (p_cs_frame) else $error("select framing");

    property p_tmo_end;
        @(posedge mclk_i) disable iff (!nrst_i)
            (tmo_act_r && !clk_edge && idle_cnt_r >= tmo_cyc_r) |=> !tmo_act_r;
    endproperty
    a_tmo_end: assert property (p_tmo_end) else $error("timeout did not close frame");

    property p_len_range;
        @(posedge mclk_i) disable iff (!nrst_i)
            cfg_wr_i |=> pattern_length_o >= 7'h04 && pattern_length_o <= 7'h60;
    endproperty
    a_len_range: assert property (p_len_range) else $error("pattern length out of range");

    property p_edge;
        @(posedge mclk_i) disable iff (!nrst_i) (samp && edge_r == SSTM_EDGE_FALL)
            |-> !lvl_r[I_CLK] && $past(lvl_r[I_CLK]);
    endproperty
    a_edge: assert property (p_edge) else $error("sample on wrong edge");

    property p_msb_first;
        @(posedge mclk_i) disable iff (!nrst_i)
            (frame_now && samp && start && order_r == SSTM_ORDER_MSB && !cfg_wr_i)
            |=> cap_r[len_r - 7'h01] == $past(data_bit);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit misplaced");

    property p_miso_rb;
        @(posedge mclk_i) disable iff (!nrst_i) (cfg_wr_i && slave_out_source_select_i <= 5'h13)
            |=> slave_out_source_select_o == $past(slave_out_source_select_i);
    endproperty
    a_miso_rb: assert property (p_miso_rb) else $error("slave-out source readback");
endmodule

// ---- sim/sstm_spi_model.sv ----
// Behavioural SPI master that drives the probed clock, data and select lines
`timescale 1ns/1ps
module sstm_spi_model (
    output logic sclk_o,
    output logic mosi_o,
    output logic miso_o,
    output logic cs_o
);
    // Serial clock rests low between frames; select starts inactive
    initial begin
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        miso_o = 1'b0;
        cs_o   = 1'b0;
    end

    // One frame, most significant bit of the vectors first, 160 ns per bit
    task automatic xfer(input logic [95:0] mo, input logic [95:0] mi, input int n);
        int i;
        cs_o = 1'b1;
        #200;
        for (i = n - 1; i >= 0; i--) begin
            mosi_o = mo[i];
            miso_o = mi[i];
            #40 sclk_o = 1'b1; // Data settled 40 ns before the rising edge and held 40 ns past the falling edge
            #80 sclk_o = 1'b0;
            #40;
        end
        #200 cs_o = 1'b0;
        // Lines released with no pull: show the inverse so stale bits cannot match
        mosi_o = ~mosi_o;
        miso_o = ~miso_o;
        #400;
    endtask
endmodule

// ---- sim/sstm_trigger_bench.sv ----
// Self-checking bench for the serial SPI pattern trigger
`timescale 1ns/1ps
module sstm_trigger_bench;
    import sstm_pkg::*;
    logic        mclk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        cfg_wr = 1'b0;
    logic [4:0]  src_mi = 5'h06;
    logic [4:0]  src_cs = 5'h07;
    logic [4:0]  src_mo = 5'h05;
    logic [4:0]  src_ncs = 5'h08;
    logic [7:0]  thr_mi = 8'h80;
    logic [22:0] tmo    = 23'h0000C8;
    logic [7:0]  ana_ch2;
    sstm_frame_t frm    = SSTM_FRM_CS;
    sstm_line_t  line   = SSTM_LINE_MOSI;
    sstm_order_t order  = SSTM_ORDER_MSB;
    sstm_edge_t  edge_s = SSTM_EDGE_RISE;
    logic [6:0]  len    = 7'h08;
    logic [95:0] pat    = '0;
    logic [95:0] care   = '0;
    logic        sclk, mosi, miso, cs, trig, fr_act;
    logic [4:0]  rb_clk, rb_mi, rb_cs, rb_ncs, rb_mo;
    sstm_line_t  rb_line;
    sstm_order_t rb_order;
    sstm_edge_t  rb_edge;
    logic [6:0]  bit_cnt;
    logic [7:0]  rb_thr;
    logic [6:0]  rb_len;
    logic [22:0] rb_tmo;
    sstm_frame_t rb_frm;
    int          n_fail = 0;
    int          num_checks = 0;
    int          n_trig = 0;

    always #5 mclk_i = ~mclk_i;

    // Analog channel two follows slave-out, sitting exactly on the slice level when high
    assign ana_ch2 = miso ? 8'h80 : 8'h7F;

    sstm_spi_model spi (.sclk_o(sclk), .mosi_o(mosi), .miso_o(miso), .cs_o(cs));

    sstm_trigger uut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .ana_codes_i({16'h0000, ana_ch2, 8'h00}),
        .dig_lines_i({11'h000, ~cs, cs, miso, mosi, sclk}), .cfg_wr_i(cfg_wr),
        .serial_clock_source_select_i(5'h04), .serial_clock_threshold_i(8'h80),
        .master_out_source_select_i(src_mo), .master_out_threshold_i(8'h80),
        .slave_out_source_select_i(src_mi), .slave_out_threshold_i(thr_mi),
        .select_line_source_i(src_cs), .select_line_threshold_i(8'h80),
        .inverted_select_line_source_i(src_ncs), .inverted_select_line_threshold_i(8'h80),
        .framing_type_select_i(frm), .watched_data_line_i(line), .pattern_length_i(len),
        .bit_order_select_i(order), .sample_edge_select_i(edge_s),
        .clock_idle_timeout_i(tmo), .bit_pattern_i(pat), .bit_pattern_care_i(care),
        .serial_clock_source_select_o(rb_clk), .serial_clock_threshold_o(),
        .master_out_source_select_o(rb_mo), .master_out_threshold_o(),
        .slave_out_source_select_o(rb_mi), .slave_out_threshold_o(rb_thr),
        .select_line_source_o(rb_cs), .select_line_threshold_o(),
        .inverted_select_line_source_o(rb_ncs), .inverted_select_line_threshold_o(),
        .framing_type_select_o(rb_frm), .watched_data_line_o(rb_line),
        .bit_order_select_o(rb_order), .sample_edge_select_o(rb_edge),
        .pattern_length_o(rb_len), .clock_idle_timeout_o(rb_tmo),
        .trigger_o(trig), .frame_active_o(fr_act), .bit_count_o(bit_cnt)
    );

    // Trigger pulses counted so that a double fire in one frame shows up
    always @(posedge mclk_i) begin
        if (trig === 1'b1) n_trig <= n_trig + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Settings are latched by a one-cycle write strobe
    task automatic cfg();
        @(posedge mclk_i);
        #1 cfg_wr = 1'b1;
        @(posedge mclk_i);
        #1 cfg_wr = 1'b0;
    endtask

    // Configure, send one frame, then compare the number of triggers it produced
    task automatic run(input sstm_frame_t f, input sstm_line_t l, input sstm_order_t o,
                       input sstm_edge_t e, input logic [6:0] n_len, input logic [95:0] p,
                       input logic [95:0] c, input logic [95:0] mo, input logic [95:0] mi,
                       input int nb, input int exp);
        int t0;
        #1;
        frm    = f;
        line   = l;
        order  = o;
        edge_s = e;
        len    = n_len;
        pat    = p;
        care   = c;
        cfg();
        chk({rb_line, rb_order, rb_edge}, {l, o, e});
        repeat (3) @(posedge mclk_i);
        t0 = n_trig;
        // Pin changes kept off the sampling edge
        #1 spi.xfer(mo, mi, nb);
        repeat (10) @(posedge mclk_i);
        chk(n_trig - t0, exp);
        chk(fr_act, 1'b0);
        chk(bit_cnt, 7'h00);
    endtask

    task automatic stop_test();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Generous against roughly 43 us of traffic, well inside the cycle budget
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge mclk_i);
        #1 nrst_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        chk(rb_thr, 8'h80);
        chk(rb_len, 7'h08);
        chk(rb_tmo, 23'h0007D0);
        chk(rb_clk, 5'h00);
        cfg();
        chk(rb_mi, 5'h06);
        chk(rb_cs, 5'h07);
        chk(rb_ncs, 5'h08);
        chk(rb_tmo, 23'h0000C8);
        // Out-of-range codes must leave the previous settings in place
        #1 src_cs = 5'h14;
        src_ncs = 5'h15;
        src_mo = 5'h1F;
        frm = sstm_frame_t'(2'h3);
        cfg();
        chk(rb_cs, 5'h07);
        chk(rb_ncs, 5'h08);
        chk(rb_mo, 5'h05);
        chk(rb_frm, SSTM_FRM_CS);
        src_cs = 5'h07;
        src_ncs = 5'h08;
        src_mo = 5'h05;
        run(SSTM_FRM_CS, SSTM_LINE_MOSI, SSTM_ORDER_MSB, SSTM_EDGE_RISE, 7'h08,
            96'hA5, 96'hFF, 96'hA5, 96'h00, 8, 1);
        run(SSTM_FRM_CS, SSTM_LINE_MISO, SSTM_ORDER_MSB, SSTM_EDGE_RISE, 7'h08,
            96'hA5, 96'hFF, 96'hA5, 96'h00, 8, 0);
        run(SSTM_FRM_CS, SSTM_LINE_MOSI, SSTM_ORDER_LSB, SSTM_EDGE_RISE, 7'h08,
            96'hF0, 96'hFF, 96'h0F, 96'h00, 8, 1);
        run(SSTM_FRM_CS, SSTM_LINE_MOSI, SSTM_ORDER_LSB, SSTM_EDGE_RISE, 7'h08,
            96'h0F, 96'hFF, 96'h0F, 96'h00, 8, 0);
        run(SSTM_FRM_CS, SSTM_LINE_MOSI, SSTM_ORDER_MSB, SSTM_EDGE_RISE, 7'h08,
            96'h03, 96'h0F, 96'h63, 96'h00, 8, 1);
        run(SSTM_FRM_CS, SSTM_LINE_MOSI, SSTM_ORDER_MSB, SSTM_EDGE_RISE, 7'h08,
            96'h03, 96'h0F, 96'h62, 96'h00, 8, 0);
        run(SSTM_FRM_NCS, SSTM_LINE_MOSI, SSTM_ORDER_MSB, SSTM_EDGE_FALL, 7'h08,
            96'h5A, 96'hFF, 96'h5A, 96'h00, 8, 1);
        run(SSTM_FRM_TMO, SSTM_LINE_MOSI, SSTM_ORDER_MSB, SSTM_EDGE_RISE, 7'h04,
            96'h9, 96'hF, 96'h9, 96'h00, 4, 1);
        run(SSTM_FRM_CS, SSTM_LINE_MOSI, SSTM_ORDER_MSB, SSTM_EDGE_RISE, 7'h0C,
            96'hABC, 96'hFFF, 96'hAB, 96'h00, 8, 0);
        run(SSTM_FRM_CS, SSTM_LINE_MOSI, SSTM_ORDER_MSB, SSTM_EDGE_RISE, 7'h04,
            96'h9, 96'hF, 96'h99, 96'h00, 8, 1);
        run(SSTM_FRM_CS, SSTM_LINE_MOSI, SSTM_ORDER_MSB, SSTM_EDGE_RISE, 7'h60,
            96'hF0E1_D2C3_B4A5_9687_7869_5A4B, '1,
            96'hF0E1_D2C3_B4A5_9687_7869_5A4B, 96'h00, 96, 1);
        #1 src_mi = 5'h01;
        run(SSTM_FRM_CS, SSTM_LINE_MISO, SSTM_ORDER_MSB, SSTM_EDGE_RISE, 7'h08,
            96'hC3, 96'hFF, 96'h00, 96'hC3, 8, 1);
        // A high code just below the slice level must read as low
        #1 thr_mi = 8'h81;
        run(SSTM_FRM_CS, SSTM_LINE_MISO, SSTM_ORDER_MSB, SSTM_EDGE_RISE, 7'h08,
            96'hC3, 96'hFF, 96'h00, 96'hC3, 8, 0);
        chk(rb_thr, 8'h81);
        // Timeout reads back as written; lengths outside the range are clamped
        #1 tmo = 23'h7FFFFF;
        len = 7'h02;
        cfg();
        chk(rb_tmo, 23'h7FFFFF);
        chk(rb_len, 7'h04);
        #1 len = 7'h7F;
        cfg();
        chk(rb_len, 7'h60);
        stop_test();
    end
endmodule
